// ===== common/pip_map.vh
`ifndef PIP_MAP_VH
`define PIP_MAP_VH
// register byte offsets
`define PIP_MASK_OFS 12'h0_000
`define PIP_VECT_OFS 12'h0_004
`define PIP_TRIG_OFS 12'h0_008
`define PIP_PEND_OFS 12'h0_00C
`define PIP_CTRL_OFS 12'h0_040
// control register field positions
`define PIP_LVL_HI 7
`define PIP_LVL_LO 5
`define PIP_PEND_BIT 3
// source count and vector table
`define PIP_NSRC 19
`define PIP_VEC_BASE 16'h0094
`define PIP_VEC_STEP 16'h0004
// reset values and the disabled level
`define PIP_LVL_RST 3'h7
`define PIP_MASK_RST 3'h0
`define PIP_LVL_OFF 3'h7
`endif

// ===== hw/pip_icu.v
`timescale 1ns/1ps
`include "pip_map.vh"

// ==========================================
// design notes
// - one request to the cpu at a time: once raised it freezes the winner,
//   so the readout and next mask cannot move under a handler's feet
// - arbitration is a plain combinational scan of 19 sources; cheap at
//   this size, and it keeps the answer one edge after pending is seen
// - the next mask is the accepted level, so equal or higher levels stay
//   blocked until software restores the saved mask
// - a vector read with no request raised is harmless: nothing clears
// - level sources cannot be cleared by software or by the vector read;
//   they stay pending while their input is high, by intent
// - the break path has no mask and no enable, only an edge detector;
//   its history flop resets high so no false edge follows reset
// - apb answers with no wait state; read data is a flop loaded in the setup phase
// - unmapped addresses answer with an error and change nothing

module pip_icu (
   // apb slave
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // peripheral requests, synchronous to pclk
   input wire [18:0] periph_req,
   input wire system_break_input_n,
   // to cpu core
   output reg external_interrupt_request,
   output reg system_break_irq
);

// ==========================================
// register state
reg [2:0] lvl_reg [0:18];
reg [18:0] pend_reg;
reg [18:0] trig_level_reg;
reg [2:0] accept_mask_level;
reg [15:0] vector_readout;
reg [4:0] acc_idx_reg;
reg [2:0] next_mask_reg;
reg brk_prev_reg;

// ==========================================
// bus decode
wire setup_ph = psel & ~penable;
wire done = psel & penable & pready;
wire wr_done = done & pwrite;
wire rd_done = done & ~pwrite;
wire mask_wr = wr_done && (paddr == `PIP_MASK_OFS);
wire vect_rd = rd_done && (paddr == `PIP_VECT_OFS) && external_interrupt_request;

// control register index for an address, 31 when not a control register
function [4:0] ctrl_index;
   input [11:0] a;
   begin
      if (a >= `PIP_CTRL_OFS && a < `PIP_CTRL_OFS + 12'h04C && a[1:0] == 2'b00) begin
         ctrl_index = a[6:2] - 5'd16;
      end else begin
         ctrl_index = 5'd31;
      end
   end
endfunction

wire [4:0] sel_idx = ctrl_index(paddr);

// ==========================================
// arbitration: best level first, then fixed order
reg [2:0] best_lvl;
reg [4:0] best_idx;
reg any_req;
integer i;
always @* begin
   best_lvl = `PIP_LVL_OFF;
   best_idx = 5'd0;
   any_req = 1'b0;
   for (i = `PIP_NSRC - 1; i >= 0; i = i - 1) begin
      // level 7 is never a candidate
      if (pend_reg[i] && lvl_reg[i] != `PIP_LVL_OFF && lvl_reg[i] <= best_lvl) begin
         best_lvl = lvl_reg[i]; // keep lowest level
         best_idx = i[4:0]; // downward scan lets lower address win ties
         any_req = 1'b1;
      end
   end
end

// winner must be numerically below mask
wire accept = any_req && (best_lvl < accept_mask_level) && !external_interrupt_request;

// ==========================================
// pending bits and control registers
genvar g;
generate
   for (g = 0; g < `PIP_NSRC; g = g + 1) begin : g_src
      wire sw_wr = wr_done && (sel_idx == g);
      always @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            lvl_reg[g] <= `PIP_LVL_RST;
            pend_reg[g] <= 1'b0;
         end else begin
            if (sw_wr) begin
               lvl_reg[g] <= pwdata[`PIP_LVL_HI:`PIP_LVL_LO];
            end
            if (trig_level_reg[g]) begin
               pend_reg[g] <= periph_req[g]; // follows input, writes ignored
            end else if (sw_wr) begin
               pend_reg[g] <= pwdata[`PIP_PEND_BIT]; // software write wins over set
            end else if (vect_rd && acc_idx_reg == g) begin
               pend_reg[g] <= 1'b0; // vector read clear wins over set
            end else if (periph_req[g]) begin
               pend_reg[g] <= 1'b1; // hardware set
            end
         end
      end
   end
endgenerate

// ==========================================
// request to cpu, mask and vector readout
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      external_interrupt_request <= 1'b0;
      accept_mask_level <= `PIP_MASK_RST;
      vector_readout <= 16'h0000;
      acc_idx_reg <= 5'd0;
      next_mask_reg <= `PIP_MASK_RST;
      trig_level_reg <= 19'h0_0000;
   end else begin
      if (wr_done && paddr == `PIP_TRIG_OFS) begin
         trig_level_reg <= pwdata[18:0];
      end
      if (mask_wr) begin
         accept_mask_level <= pwdata[2:0];
         external_interrupt_request <= 1'b0; // re-arm
      end else if (vect_rd) begin
         accept_mask_level <= next_mask_reg;
         external_interrupt_request <= 1'b0; // re-arm
      end else if (accept) begin
         external_interrupt_request <= 1'b1;
         acc_idx_reg <= best_idx;
         next_mask_reg <= best_lvl;
         // low half of entry address
         vector_readout <= `PIP_VEC_BASE + {11'h000, best_idx} * `PIP_VEC_STEP;
      end
   end
end

// ==========================================
// break input: pulse on falling edge, no mask applies
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      brk_prev_reg <= 1'b1;
      system_break_irq <= 1'b0;
   end else begin
      brk_prev_reg <= system_break_input_n;
      system_break_irq <= brk_prev_reg & ~system_break_input_n;
   end
end

// ==========================================
// apb answer: no wait state, read data comes from a flop loaded in the setup phase
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
   end else begin
      pready <= setup_ph;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (setup_ph) begin
         if (paddr == `PIP_MASK_OFS) begin
            prdata <= {29'h0000_0000, accept_mask_level};
         end else if (paddr == `PIP_VECT_OFS) begin
            prdata <= {16'h0000, vector_readout};
         end else if (paddr == `PIP_TRIG_OFS) begin
            prdata <= {13'h0000, trig_level_reg};
         end else if (paddr == `PIP_PEND_OFS) begin
            prdata <= {13'h0000, pend_reg};
         end else if (sel_idx != 5'd31) begin
            prdata <= {24'h00_0000, lvl_reg[sel_idx], 1'b0, pend_reg[sel_idx], 3'b000};
         end else begin
            pslverr <= 1'b1; // unmapped address
         end
      end
   end
end

endmodule // pip_icu

// ===== verification/pip_cpu_model.sv
`timescale 1ns/1ps
// =====
// cpu core stand-in
module pip_cpu_model (
   input wire pclk, presetn, cpu_interrupt_enable,
   input wire external_interrupt_request, system_break_irq,
   output logic irq_taken,
   output int brk_cnt);
   // maskable request gated by enable; break counted whatever the enable
   always @(posedge pclk or negedge presetn)
      if (!presetn) begin
         irq_taken <= 1'b0;
         brk_cnt <= 0;
      end else begin
         // taking it means a branch to the fixed trap entry
         // handler saves state before it re-enables, for nesting
         irq_taken <= external_interrupt_request && cpu_interrupt_enable;
         brk_cnt <= brk_cnt + system_break_irq;
      end
endmodule // pip_cpu_model

// ===== verification/pip_icu_props.sv
`timescale 1ns/1ps
// =====
// port checker
module pip_icu_props (
   input wire pclk, presetn, psel, penable, pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata, prdata,
   input wire pready, pslverr, system_break_input_n,
   input wire [18:0] periph_req,
   input wire external_interrupt_request, system_break_irq);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire ok = psel && penable && pready && !pslverr;
   wire vrd = ok && !pwrite && paddr == 12'h004;
   wire mwr = ok && pwrite && paddr == 12'h000;
   reg mask_zero_reg;
   // a zero mask admits nothing, so the request must stay low
   always @(posedge pclk or negedge presetn)
      if (!presetn) mask_zero_reg <= 1'b1;
      else if (mwr) mask_zero_reg <= pwdata[2:0] == 3'h0;
   property p_rdy; psel && !penable |=> pready ##1 !pready; endproperty
   a_rdy: assert property (p_rdy) else $error("pready timing wrong");
   // a vector read with no request raised has no effect, so it is left out
   property p_drop;
      (vrd && external_interrupt_request) || mwr |=> !external_interrupt_request;
   endproperty
   a_drop: assert property (p_drop) else $error("request kept");
   property p_hold;
      external_interrupt_request && !vrd && !mwr |=> external_interrupt_request;
   endproperty
   a_hold: assert property (p_hold) else $error("request lost");
   property p_mask0; mask_zero_reg |-> !external_interrupt_request; endproperty
   a_mask0: assert property (p_mask0) else $error("request at mask 0");
   property p_vec; vrd && external_interrupt_request |-> prdata[31:16] == 16'h0000
      && prdata[1:0] == 2'h0 && prdata[15:0] >= 16'h0094 && prdata[15:0] <= 16'h00dc;
   endproperty
   a_vec: assert property (p_vec) else $error("vector out of table");
   property p_brk; $fell(system_break_input_n) |-> ##1 system_break_irq; endproperty
   a_brk: assert property (p_brk) else $error("break missed");
   property p_pulse; system_break_irq |=> !system_break_irq; endproperty
   a_pulse: assert property (p_pulse) else $error("break too long");
   property p_err; pready && pslverr |-> prdata == 32'h0000_0000; endproperty
   a_err: assert property (p_err) else $error("error read not zero");
   c_vrd: cover property (vrd && external_interrupt_request);
   c_brk: cover property (system_break_irq);
   c_err: cover property (pready && pslverr);
endmodule // pip_icu_props
bind pip_icu pip_icu_props chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .prdata, .pready, .pslverr, .system_break_input_n, .periph_req,
   .external_interrupt_request, .system_break_irq);

// ===== verification/pip_icu_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin failures++; \
   $display("unexpected at %0t got %h want %h", $time, a, b); end end
// =====
// bench
module pip_icu_tb;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, brk_n = 1, err;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, rd;
   logic [18:0] req = 0;
   wire [31:0] prdata;
   wire pready, pslverr, eir, system_break_input, taken;
   int brk_cnt, failures = 0, compares = 0;
   always #4 pclk = ~pclk;
   pip_icu dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .periph_req(req), .system_break_input_n(brk_n),
      .external_interrupt_request(eir), .system_break_irq(system_break_input));
   pip_cpu_model cpu_u (.pclk, .presetn, .cpu_interrupt_enable(1'b1),
      .external_interrupt_request(eir), .system_break_irq(system_break_input), .irq_taken(taken), .brk_cnt);
   // one transfer, held until pready; an idle cycle after avoids double drives
   task apb(input bit w, input [11:0] a, input [31:0] d);
      int n;
      n = 0;
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk) penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
      if (n >= 20) failures++;
      rd = prdata;
      err = pslverr;
      psel <= 0; penable <= 0;
      @(posedge pclk);
   endtask
   task rd_chk(input [11:0] a, input [31:0] e);
      apb(0, a, 0);
      `CHK(rd, e)
   endtask
   task wait_eir;
      int n;
      n = 0;
      while (eir !== 1'b1 && n < 10) begin @(posedge pclk); n++; end
      `CHK(eir, 1'b1)
      @(posedge pclk);
      `CHK(taken, 1'b1)
   endtask
   task tally_and_finish;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1;
      rd_chk(12'h000, 32'h0000_0000);
      rd_chk(12'h040, 32'h0000_00e0);
      apb(0, 12'hff0, 0); `CHK(err, 1'b1)
      $display("test reset done");
      // sources 0 and 2 at level 3, 5 at level 1, 3 left disabled
      apb(1, 12'h040, 32'h0000_0060); apb(1, 12'h048, 32'h0000_0060);
      apb(1, 12'h054, 32'h0000_0020);
      req <= 19'h0_002d; @(posedge pclk) req <= 0;
      repeat (4) @(posedge pclk); `CHK(eir, 1'b0)
      apb(1, 12'h000, 32'h0000_0007); wait_eir;
      rd_chk(12'h000, 32'h0000_0007);
      rd_chk(12'h004, 32'h0000_00a8);
      `CHK(rd[15], 1'b0)
      `CHK(rd[1:0], 2'b00)
      `CHK(eir, 1'b0)
      rd_chk(12'h000, 32'h0000_0001);
      rd_chk(12'h00c, 32'h0000_000d);
      apb(1, 12'h000, 32'h0000_0007); wait_eir;
      rd_chk(12'h004, 32'h0000_0094);
      apb(1, 12'h000, 32'h0000_0007); wait_eir;
      rd_chk(12'h004, 32'h0000_009c);
      apb(1, 12'h000, 32'h0000_0007); repeat (4) @(posedge pclk);
      `CHK(eir, 1'b0)
      $display("test arbitration done");
      apb(1, 12'h008, 32'h0004_0000); apb(1, 12'h088, 32'h0000_00c0);
      req <= 19'h4_0000; wait_eir;
      rd_chk(12'h004, 32'h0000_00dc);
      rd_chk(12'h00c, 32'h0004_0008);
      apb(1, 12'h088, 32'h0000_00c0); rd_chk(12'h088, 32'h0000_00c8);
      req <= 0; repeat (2) @(posedge pclk);
      rd_chk(12'h00c, 32'h0000_0008);
      $display("test level source done");
      brk_n <= 0; repeat (5) @(posedge pclk); brk_n <= 1;
      repeat (3) @(posedge pclk); `CHK(brk_cnt, 1)
      $display("test break done");
      tally_and_finish; // stop after break
   end
   // hang guard, far beyond the hundred or so cycles the tests need
   initial begin #20000; failures++; tally_and_finish; end
endmodule // pip_icu_tb
